/* File: rtl/llem_pkg.sv */
// package of constants for the line loss and error maintenance block
package llem_pkg;
    // ==================================================
    // register offsets
    localparam logic [7:0] LLEM_RX_CODE_OFS = 8'h28;
    localparam logic [7:0] LLEM_RX_LEVEL_OFS = 8'h29;
    localparam logic [7:0] LLEM_SLICER_OFS = 8'h2a;
    localparam logic [7:0] LLEM_LOOP_OFS = 8'h2b;
    localparam logic [7:0] LLEM_ALARM_OFS = 8'h2c;
    localparam logic [7:0] LLEM_ERRCTL_OFS = 8'h31;
    localparam logic [7:0] LLEM_CNT_LO_OFS = 8'h40;
    localparam logic [7:0] LLEM_CNT_HI_OFS = 8'h41;
    localparam logic [7:0] LLEM_STATUS_OFS = 8'h42;
    // ==================================================
    // reset values
    localparam logic [7:0] LLEM_RX_LEVEL_RST = 8'h15;
    localparam logic [7:0] LLEM_SLICER_RST = 8'h18;
    // ==================================================
    // field positions
    localparam int LLEM_LONG_HAUL_BIT = 6;
    localparam int LLEM_CRIT_BIT = 2;
    localparam int LLEM_RX_ONES_BIT = 1;
    localparam int LLEM_TX_ONES_BIT = 0;
    localparam int LLEM_BPV_BIT = 6;
    localparam int LLEM_ZCRIT_BIT = 4;
    localparam int LLEM_MODE_BIT = 1;
    localparam int LLEM_TRF_BIT = 0;
    // ==================================================
    // levels and counts
    localparam logic [5:0] LLEM_Q_BASE_DB = 6'h04;
    localparam logic [5:0] LLEM_Q_MAX_DB = 6'h30;
    localparam logic [5:0] LLEM_HYST_DB = 6'h04;
    localparam logic [4:0] LLEM_Q_SAT_CODE = 5'h16;
    localparam logic [11:0] LLEM_SH_DECLARE_MV = 12'd800;
    localparam logic [11:0] LLEM_SH_CLEAR_MV = 12'd1000;
    localparam logic [10:0] LLEM_DECL_SHORT = 11'd175;
    localparam logic [10:0] LLEM_DECL_LONG = 11'd1544;
    localparam logic [6:0] LLEM_CLR_WINDOW = 7'd127;
    localparam logic [7:0] LLEM_MIN_ONES = 8'd16;
    localparam logic [7:0] LLEM_MAX_ZRUN = 8'd100;
    localparam logic [7:0] LLEM_Z_B8ZS = 8'd7;
    localparam logic [7:0] LLEM_Z_AMI_ANSI = 8'd15;
    localparam logic [7:0] LLEM_Z_AMI_FCC = 8'd80;
    localparam logic [1:0] LLEM_CNT_ON = 2'b01;
    localparam logic [5:0] LLEM_GAIN_HI_DB = 6'd22;
    localparam int LLEM_CLK_HZ = 25000000;
    localparam int LLEM_REPORT_S = 1;
    localparam int LLEM_REPORT_CYC = LLEM_CLK_HZ * LLEM_REPORT_S;
endpackage

/* File: rtl/llem_top.sv */
// line supervision, loopback and excessive-zero maintenance logic
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RL1) long haul: code sets -4..-48 dB threshold
// (RL2) slicer mark at 40/50/60/70% of peak
// (RL3) peak window 32/64/128/256 bit periods
// (RL4) monitor gain 0 or 22 dB
// (RL5) six independent loopback enables
// (RL6) declare after 175 or 1544 low bits
// (RL7) short haul: declare below 800, clear above 1000
// (RL8) long haul: clear needs 4 dB hysteresis
// (RL9) clear needs density and zero-run in 128 bits
// (RL10) receive all ones during loss if enabled
// (RL11) transmit all ones during loss if enabled
// (RL12) one violation per rising insert bit
// (RL13) zero limit 15 AMI, 7 B8ZS
// (RL14) alternate criterion: 80 AMI, 7 B8ZS
// (RL15) count errors only when enable field 01
// (RL16) manual mode: snapshot on rising transfer bit
// (RL17) auto mode: snapshot once per second
// (RL18) line code bit picks B8ZS or AMI
// (RL19) equalizer bit picks long or short haul
// (RL20) software toggles transfer bit per snapshot
// (RL21) low-bit counter restarts, reset clears loss
// (RL22) error counter saturates until transfer
module llem_top #(
    parameter int REPORT_CYC = llem_pkg::LLEM_REPORT_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // analog front end measurements
    input  wire logic [11:0] rx_amp_mv,
    input  wire logic [5:0]  rx_atten_db,
    // bit stream, same clock
    input  wire logic        bit_tick,
    input  wire logic        rx_data,
    input  wire logic        tx_data,
    // stream outputs
    output logic             rx_data_out,
    output logic             tx_data_out,
    output logic             tx_bpv,
    output logic             rx_mark,
    output logic             loss_of_signal,
    // analog settings
    output logic      [11:0] slice_level_mv,
    output logic      [5:0]  loss_thresh_db,
    output logic      [5:0]  monitor_gain_db,
    // loopback enables
    output logic             local_digital_loop1_en,
    output logic             system_local_loop_en,
    output logic             system_remote_loop_en,
    output logic             remote_loop_en,
    output logic             analog_loop_en,
    output logic             local_digital_loop2_en
);
    import llem_pkg::*;

    // ==================================================
    // registers
    logic [7:0]  code_q, level_q, slicer_q, loop_q, alarm_q, errctl_q;
    logic [15:0] snap_q;
    logic        los_q;
    logic        long_haul_sel, rx_line_code_sel, loss_criterion_sel;
    logic        zero_limit_criterion, report_mode_sel;
    logic [1:0]  zero_count_enable;
    logic [4:0]  loss_threshold_sel;

    assign rx_line_code_sel = code_q[0];
    assign long_haul_sel = level_q[LLEM_LONG_HAUL_BIT];
    assign loss_threshold_sel = level_q[4:0];
    assign loss_criterion_sel = alarm_q[LLEM_CRIT_BIT];
    assign zero_limit_criterion = errctl_q[LLEM_ZCRIT_BIT];
    assign zero_count_enable = errctl_q[3:2];
    assign report_mode_sel = errctl_q[LLEM_MODE_BIT];

    // register writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code_q   <= 8'h00;
            level_q  <= LLEM_RX_LEVEL_RST;
            slicer_q <= LLEM_SLICER_RST;
            loop_q   <= 8'h00;
            alarm_q  <= 8'h00;
            errctl_q <= 8'h00;
        end else if (reg_wr) begin
            unique case (reg_addr)
                LLEM_RX_CODE_OFS:  code_q <= {7'h00, reg_wdata[0]};
                LLEM_RX_LEVEL_OFS: level_q <= reg_wdata & 8'h5f;
                LLEM_SLICER_OFS:   slicer_q <= reg_wdata & 8'h3f;
                LLEM_LOOP_OFS:     loop_q <= reg_wdata & 8'h77; // RL5
                LLEM_ALARM_OFS:    alarm_q <= reg_wdata & 8'h07;
                LLEM_ERRCTL_OFS:   errctl_q <= reg_wdata & 8'h5f;
                default: ;
            endcase
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                LLEM_RX_CODE_OFS:  reg_rdata <= code_q;
                LLEM_RX_LEVEL_OFS: reg_rdata <= level_q;
                LLEM_SLICER_OFS:   reg_rdata <= slicer_q;
                LLEM_LOOP_OFS:     reg_rdata <= loop_q;
                LLEM_ALARM_OFS:    reg_rdata <= alarm_q;
                LLEM_ERRCTL_OFS:   reg_rdata <= errctl_q;
                LLEM_CNT_LO_OFS:   reg_rdata <= snap_q[7:0];
                LLEM_CNT_HI_OFS:   reg_rdata <= snap_q[15:8];
                LLEM_STATUS_OFS:   reg_rdata <= {7'h00, los_q};
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // loopback enables straight from the control register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            local_digital_loop1_en <= 1'b0;
            system_local_loop_en   <= 1'b0;
            system_remote_loop_en  <= 1'b0;
            remote_loop_en         <= 1'b0;
            analog_loop_en         <= 1'b0;
            local_digital_loop2_en <= 1'b0;
        end else begin
            local_digital_loop1_en <= loop_q[6]; // RL5
            system_local_loop_en   <= loop_q[5]; // RL5
            system_remote_loop_en  <= loop_q[4]; // RL5
            remote_loop_en         <= loop_q[2]; // RL5
            analog_loop_en         <= loop_q[1]; // RL5
            local_digital_loop2_en <= loop_q[0]; // RL5
        end
    end

    // ==================================================
    // front end measurements pass two flops
    logic [11:0] amp_s1_q, amp_q;
    logic [5:0]  att_s1_q, att_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            amp_s1_q <= 12'h000;
            amp_q    <= 12'h000;
            att_s1_q <= 6'h00;
            att_q    <= 6'h00;
        end else begin
            amp_s1_q <= rx_amp_mv;
            amp_q    <= amp_s1_q;
            att_s1_q <= rx_atten_db;
            att_q    <= att_s1_q;
        end
    end

    // ==================================================
    // thresholds and analog settings
    logic [5:0] q_db;
    logic [3:0] pct_tenths;
    logic [7:0] win_last;

    always_comb begin
        if (loss_threshold_sel >= LLEM_Q_SAT_CODE) begin
            q_db = LLEM_Q_MAX_DB; // RL1
        end else begin
            q_db = LLEM_Q_BASE_DB + {loss_threshold_sel, 1'b0}; // RL1
        end
        pct_tenths = 4'd4 + {2'b00, slicer_q[5:4]}; // RL2
        win_last = 8'((32 << slicer_q[3:2]) - 1); // RL3
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loss_thresh_db  <= 6'h00;
            monitor_gain_db <= 6'h00;
        end else begin
            loss_thresh_db <= long_haul_sel ? q_db : 6'h00; // RL19
            // reserved gain codes fall back to 0 dB
            monitor_gain_db <= (slicer_q[1:0] == 2'b01) ? LLEM_GAIN_HI_DB : 6'h00; // RL4
        end
    end

    // ==================================================
    // peak observation and data slicer
    logic [7:0]  win_cnt_q;
    logic [11:0] run_max_q, peak_q;
    logic [15:0] slice_prod;

    assign slice_prod = 16'(peak_q * pct_tenths);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_cnt_q <= 8'h00;
            run_max_q <= 12'h000;
            peak_q    <= 12'h000;
        end else if (bit_tick) begin
            if (win_cnt_q >= win_last) begin
                win_cnt_q <= 8'h00; // RL3
                peak_q    <= (amp_q > run_max_q) ? amp_q : run_max_q;
                run_max_q <= 12'h000;
            end else begin
                win_cnt_q <= win_cnt_q + 8'h01;
                if (amp_q > run_max_q) begin
                    run_max_q <= amp_q;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slice_level_mv <= 12'h000;
            rx_mark        <= 1'b0;
        end else begin
            slice_level_mv <= 12'(slice_prod / 16'd10); // RL2
            rx_mark        <= amp_q > slice_level_mv; // RL2
        end
    end

    // ==================================================
    // loss of signal declare and clear
    logic        low_cond, clr_cond;
    logic [10:0] low_cnt_q, decl_cnt;
    logic [6:0]  cwin_q;
    logic [7:0]  ones_q, zrun_q;
    logic        cwin_ok_q;

    always_comb begin
        if (long_haul_sel) begin
            low_cond = att_q > q_db; // RL8
            clr_cond = att_q < (q_db - LLEM_HYST_DB); // RL8
        end else begin
            low_cond = amp_q < LLEM_SH_DECLARE_MV; // RL7
            clr_cond = amp_q > LLEM_SH_CLEAR_MV; // RL7
        end
        decl_cnt = loss_criterion_sel ? LLEM_DECL_LONG : LLEM_DECL_SHORT; // RL6
    end

    // consecutive low-level bit counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt_q <= 11'h000; // RL21
        end else if (bit_tick) begin
            if (!low_cond) begin
                low_cnt_q <= 11'h000; // RL21
            end else if (low_cnt_q < decl_cnt) begin
                low_cnt_q <= low_cnt_q + 11'h001;
            end
        end
    end

    // 128-bit clear window: level, density and zero run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cwin_q    <= 7'h00;
            ones_q    <= 8'h00;
            zrun_q    <= 8'h00;
            cwin_ok_q <= 1'b1;
            los_q     <= 1'b0; // RL21
        end else if (bit_tick) begin
            if (!los_q) begin
                cwin_q    <= 7'h00;
                ones_q    <= 8'h00;
                zrun_q    <= 8'h00;
                cwin_ok_q <= 1'b1;
                if (low_cond && low_cnt_q + 11'h001 >= decl_cnt) begin
                    los_q <= 1'b1; // RL6
                end
            end else if (cwin_q == LLEM_CLR_WINDOW) begin
                // RL9
                if (cwin_ok_q && clr_cond && zrun_q < LLEM_MAX_ZRUN
                    && ones_q + {7'h00, rx_data} >= LLEM_MIN_ONES) begin
                    los_q <= 1'b0;
                end
                cwin_q    <= 7'h00;
                ones_q    <= 8'h00;
                zrun_q    <= 8'h00;
                cwin_ok_q <= 1'b1;
            end else begin
                cwin_q <= cwin_q + 7'h01;
                ones_q <= ones_q + {7'h00, rx_data};
                zrun_q <= rx_data ? 8'h00 : zrun_q + 8'h01;
                if (!clr_cond || (!rx_data && zrun_q + 8'h01 >= LLEM_MAX_ZRUN)) begin
                    cwin_ok_q <= 1'b0; // RL9
                end
            end
        end
    end

    // ==================================================
    // all-ones insertion and violation insertion
    logic bpv_in_q, bpv_pend_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_data_out    <= 1'b0;
            tx_data_out    <= 1'b0;
            loss_of_signal <= 1'b0;
        end else begin
            loss_of_signal <= los_q;
            rx_data_out    <= rx_data | (los_q & alarm_q[LLEM_RX_ONES_BIT]); // RL10
            tx_data_out    <= tx_data | (los_q & alarm_q[LLEM_TX_ONES_BIT]); // RL11
        end
    end

    // rising insert bit arms one violation for the next transmit bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bpv_in_q   <= 1'b0;
            bpv_pend_q <= 1'b0;
            tx_bpv     <= 1'b0;
        end else begin
            bpv_in_q <= errctl_q[LLEM_BPV_BIT];
            tx_bpv   <= bit_tick & bpv_pend_q; // RL12
            if (errctl_q[LLEM_BPV_BIT] && !bpv_in_q) begin
                bpv_pend_q <= 1'b1; // RL12
            end else if (bit_tick) begin
                bpv_pend_q <= 1'b0;
            end
        end
    end

    // ==================================================
    // excessive zeros and error counting
    logic [7:0]  exz_run_q, z_limit;
    logic        exz_event, trf_q, snap_now, sec_tick;
    logic [15:0] exz_cnt_q;
    logic [31:0] sec_cnt_q;

    always_comb begin
        if (!rx_line_code_sel) begin
            z_limit = LLEM_Z_B8ZS; // RL13 RL14 RL18
        end else if (zero_limit_criterion) begin
            z_limit = LLEM_Z_AMI_FCC; // RL14
        end else begin
            z_limit = LLEM_Z_AMI_ANSI; // RL13
        end
        exz_event = bit_tick && !rx_data && exz_run_q == z_limit;
        sec_tick = sec_cnt_q == 32'(REPORT_CYC - 1);
        snap_now = report_mode_sel ? sec_tick // RL17
                 : (errctl_q[LLEM_TRF_BIT] && !trf_q); // RL16 RL20
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            exz_run_q <= 8'h00;
        end else if (bit_tick) begin
            if (rx_data) begin
                exz_run_q <= 8'h00;
            end else if (exz_run_q != 8'hff) begin
                exz_run_q <= exz_run_q + 8'h01;
            end
        end
    end

    // one second timer for auto report
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sec_cnt_q <= 32'h0;
        end else if (!report_mode_sel || sec_tick) begin
            sec_cnt_q <= 32'h0;
        end else begin
            sec_cnt_q <= sec_cnt_q + 32'h1;
        end
    end

    // internal counter, snapshot and restart; a same-cycle event counts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trf_q     <= 1'b0;
            exz_cnt_q <= 16'h0000;
            snap_q    <= 16'h0000;
        end else begin
            trf_q <= errctl_q[LLEM_TRF_BIT];
            if (snap_now) begin
                snap_q    <= exz_cnt_q; // RL16 RL17
                exz_cnt_q <= {15'h0000, exz_event && zero_count_enable == LLEM_CNT_ON};
            end else if (exz_event && zero_count_enable == LLEM_CNT_ON // RL15
                         && exz_cnt_q != 16'hffff) begin
                exz_cnt_q <= exz_cnt_q + 16'h0001; // RL22
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/llem_checker.sv */
// port checker for the line maintenance block
`timescale 1ns/1ps
`default_nettype none
module llem_checker
    import llem_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // stream
    input wire logic       bit_tick,
    input wire logic       rx_data,
    input wire logic       tx_data,
    input wire logic       rx_data_out,
    input wire logic       tx_data_out,
    input wire logic       tx_bpv,
    input wire logic       loss_of_signal,
    // settings
    input wire logic [5:0] loss_thresh_db,
    input wire logic [5:0] monitor_gain_db,
    input wire logic       local_digital_loop1_en,
    input wire logic       system_local_loop_en,
    input wire logic       system_remote_loop_en,
    input wire logic       remote_loop_en,
    input wire logic       analog_loop_en,
    input wire logic       local_digital_loop2_en
);
    // ==========================================
    // one clock domain for every property
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // read data only in the cycle after a read
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
    AST_RX_PASS: assert property (!loss_of_signal |-> rx_data_out == $past(rx_data)) else $error("rx altered");
    AST_TX_PASS: assert property (!loss_of_signal |-> tx_data_out == $past(tx_data)) else $error("tx altered");
    AST_BPV_ONE: assert property (tx_bpv |=> !tx_bpv) else $error("violation pulse too long");
    AST_BPV_TICK: assert property (tx_bpv |-> $past(bit_tick)) else $error("violation off bit");
    AST_DECL_TICK: assert property ($rose(loss_of_signal) |-> $past(bit_tick, 2)) else $error("declare off bit");
    AST_CLR_TICK: assert property ($fell(loss_of_signal) |-> $past(bit_tick, 2)) else $error("clear off bit");
    AST_THRESH: assert property (loss_thresh_db <= 6'd48 && !loss_thresh_db[0] && loss_thresh_db != 6'd2)
        else $error("threshold out of table");
    AST_GAIN: assert property (monitor_gain_db == 6'd0 || monitor_gain_db == 6'd22) else $error("bad gain");
    AST_LOOP: assert property ($changed({local_digital_loop1_en, system_local_loop_en, system_remote_loop_en,
        remote_loop_en, analog_loop_en, local_digital_loop2_en}) |-> $past(reg_wr, 2)
        && $past(reg_addr, 2) == LLEM_LOOP_OFS) else $error("loop change without write");
    // main scenarios
    COV_DECL: cover property ($rose(loss_of_signal));
    COV_CLR: cover property ($fell(loss_of_signal));
    COV_BPV: cover property (tx_bpv);
endmodule
bind llem_top llem_checker chk (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .bit_tick, .rx_data,
    .tx_data, .rx_data_out, .tx_data_out, .tx_bpv, .loss_of_signal, .loss_thresh_db, .monitor_gain_db,
    .local_digital_loop1_en, .system_local_loop_en, .system_remote_loop_en, .remote_loop_en, .analog_loop_en,
    .local_digital_loop2_en);
`default_nettype wire

/* File: bench/llem_line_model.sv */
// line front end model: bit timing, level and data pattern
`timescale 1ns/1ps
`default_nettype none
module llem_line_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // bench controls
    input  wire logic [11:0] amp_set,
    input  wire logic        zero_req,
    // line side
    output logic             bit_tick,
    output logic             rx_data,
    output logic      [11:0] rx_amp_mv,
    output logic      [5:0]  rx_atten_db,
    output logic             tx_data
);
    // a bit every cycle; marks unless a zero run is asked; tx toggles
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_tick <= 1'b0;
            rx_data <= 1'b0;
            tx_data <= 1'b0;
        end else begin
            bit_tick <= 1'b1;
            rx_data <= !zero_req;
            tx_data <= !tx_data;
        end
    end
    // level follows the bench; attenuation falls as the level rises
    assign rx_amp_mv = amp_set;
    assign rx_atten_db = 6'(60 - amp_set / 25);
endmodule
`default_nettype wire

/* File: bench/test_line_loss_and_error_maintenance.sv */
// testbench for the line maintenance block
`timescale 1ns/1ps
`default_nettype none
module test_line_loss_and_error_maintenance
    import llem_pkg::*;
;
    logic        clk, resetn, reg_wr, reg_rd, zero_req, bit_tick, rx_data, tx_data;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
    logic [11:0] amp_set, rx_amp_mv, slice_level_mv;
    logic [5:0]  rx_atten_db, loss_thresh_db, monitor_gain_db, loops;
    logic        rx_data_out, tx_data_out, tx_bpv, rx_mark, loss_of_signal, a, b;
    int          bad_count, total_checks, bpv_n, i, n, lim, seen;
    localparam logic [15:0] RT [7] = '{16'h2800, 16'h2915, 16'h2a18, 16'h2b00, 16'h2c00, 16'h3100, 16'h5000};
    localparam logic [23:0] ST [7] = '{24'h2a1916, 24'h2a1800, 24'h295630, 24'h295f30, 24'h294004, 24'h29552e,
        24'h291500};
    localparam logic [31:0] ZT [8] = '{32'h00040700, 32'h00040801, 32'h01040f00, 32'h01041001, 32'h01145000,
        32'h01145101, 32'h00140801, 32'h00080800};
    // ==========================================
    // clock, model and design
    always #20 clk = !clk;
    llem_line_model model (.clk, .resetn, .amp_set, .zero_req, .bit_tick, .rx_data, .rx_amp_mv, .rx_atten_db,
        .tx_data);
    llem_top #(.REPORT_CYC(200)) uut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rx_amp_mv, .rx_atten_db, .bit_tick, .rx_data, .tx_data, .rx_data_out, .tx_data_out, .tx_bpv, .rx_mark,
        .loss_of_signal, .slice_level_mv, .loss_thresh_db, .monitor_gain_db,
        .local_digital_loop1_en(loops[5]), .system_local_loop_en(loops[4]), .system_remote_loop_en(loops[3]),
        .remote_loop_en(loops[2]), .analog_loop_en(loops[1]), .local_digital_loop2_en(loops[0]));
    // counts violation pulses
    always @(posedge clk) if (tx_bpv === 1'b1) bpv_n++;
    // ==========================================
    // bus and compare tasks
    task automatic wr8(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd8(input logic [7:0] ad, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] d;
        rd8(ad, d);
        chk($sformatf("reg %h", ad), {8'h00, e}, {8'h00, d});
    endtask
    task automatic wait_los(input logic want);
        n = 0;
        while (loss_of_signal !== want && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("[FAIL] watchdog expected done seen timeout");
        results();
    end
    // ==========================================
    // main sequence
    initial begin
        {clk, resetn, reg_wr, reg_rd, zero_req, bad_count, total_checks, bpv_n} = '0;
        {reg_addr, reg_wdata} = '0;
        amp_set = 12'd1200;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 7; i++) rchk(RT[i][15:8], RT[i][7:0]);
        $display("test defaults done");
        wr8(LLEM_LOOP_OFS, 8'h77);
        repeat (2) @(posedge clk);
        chk("loops all", 16'h003f, {10'h0, loops});
        rchk(LLEM_LOOP_OFS, 8'h77);
        wr8(LLEM_LOOP_OFS, 8'h04);
        repeat (2) @(posedge clk);
        chk("loops one", 16'h0004, {10'h0, loops});
        for (i = 0; i < 7; i++) begin
            wr8(ST[i][23:16], ST[i][15:8]);
            repeat (3) @(posedge clk);
            chk("setting", {8'h00, ST[i][7:0]}, {10'h0, i < 2 ? monitor_gain_db : loss_thresh_db});
        end
        for (i = 0; i < 4; i++) begin
            wr8(LLEM_SLICER_OFS, 8'(i * 16));
            repeat (80) @(posedge clk);
            chk("slice", 16'(480 + 120 * i), {4'h0, slice_level_mv});
            chk("mark", 16'h0001, {15'h0, rx_mark});
        end
        wr8(LLEM_SLICER_OFS, LLEM_SLICER_RST);
        $display("test settings done");
        amp_set <= 12'd810;
        zero_req <= 1'b1;
        repeat (300) @(posedge clk);
        chk("no declare at 810", 16'h0000, {15'h0, loss_of_signal});
        for (i = 0; i < 2; i++) begin
            wr8(LLEM_ALARM_OFS, i ? 8'h05 : 8'h03);
            wr8(LLEM_RX_LEVEL_OFS, i ? 8'h4b : 8'h15);
            amp_set <= 12'd700;
            repeat (150) @(posedge clk);
            amp_set <= 12'd1200;
            repeat (3) @(posedge clk);
            amp_set <= 12'd700;
            wait_los(1'b1);
            lim = i ? 1544 : 175;
            chk("declare span", 16'(lim), 16'((n >= lim && n <= lim + 8) ? lim : n));
            @(posedge clk);
            #1 a = tx_data_out;
            chk("rx ones", {15'h0, i == 0}, {15'h0, rx_data_out});
            @(posedge clk);
            #1 b = tx_data_out;
            chk("tx ones", 16'h0003, {14'h0, a, b});
            rchk(LLEM_STATUS_OFS, 8'h01);
            amp_set <= 12'd900;
            zero_req <= 1'b0;
            repeat (300) @(posedge clk);
            chk("hold at 900", 16'h0001, {15'h0, loss_of_signal});
            amp_set <= 12'd1200;
            wait_los(1'b0);
            chk("clear span", 16'h0001, {15'h0, n >= 128 && n <= 300});
            zero_req <= i == 0;
        end
        $display("test loss done");
        for (i = 0; i < 8; i++) begin
            wr8(LLEM_RX_CODE_OFS, ZT[i][31:24]);
            wr8(LLEM_ERRCTL_OFS, ZT[i][23:16]);
            zero_req <= 1'b1;
            repeat (ZT[i][15:8]) @(posedge clk);
            zero_req <= 1'b0;
            repeat (4) @(posedge clk);
            wr8(LLEM_ERRCTL_OFS, ZT[i][23:16] | 8'h01);
            repeat (3) @(posedge clk);
            rchk(LLEM_CNT_LO_OFS, ZT[i][7:0]);
            rchk(LLEM_CNT_HI_OFS, 8'h00);
        end
        $display("test zeros done");
        wr8(LLEM_ERRCTL_OFS, 8'h06);
        zero_req <= 1'b1;
        repeat (8) @(posedge clk);
        zero_req <= 1'b0;
        seen = 0;
        repeat (120) begin
            rd8(LLEM_CNT_LO_OFS, v);
            if (v === 8'h01) seen = 1;
        end
        chk("auto snapshot", 16'h0001, 16'(seen));
        $display("test auto report done");
        wr8(LLEM_ERRCTL_OFS, 8'h00);
        n = bpv_n;
        wr8(LLEM_ERRCTL_OFS, 8'h40);
        repeat (10) @(posedge clk);
        wr8(LLEM_ERRCTL_OFS, 8'h40);
        repeat (10) @(posedge clk);
        chk("one violation", 16'h0001, 16'(bpv_n - n));
        wr8(LLEM_ERRCTL_OFS, 8'h00);
        wr8(LLEM_ERRCTL_OFS, 8'h40);
        repeat (10) @(posedge clk);
        chk("second violation", 16'h0002, 16'(bpv_n - n));
        $display("test violation done");
        results();
    end
endmodule
`default_nettype wire
